//--- hw/slpctl_pkg.sv
// package for the sleep-entry control block: register layout, encodings
// assumes one 250 MHz clock shared by both ends
package slpctl_pkg;
  localparam int          SLPCTL_TYPE_W    = 3;
  localparam int          SLPCTL_WAKE_W    = 8;
  localparam int          SLPCTL_DATA_W    = 32;
  // control word on the link: sleep type and enable in one write
  localparam int          SLPCTL_TYPE_LSB  = 10;
  localparam int          SLPCTL_EN_BIT    = 13;
  // sleep type codes; values are platform choices
  localparam logic [2:0]  SLPCTL_TYP_WORK  = 3'h0;
  localparam logic [2:0]  SLPCTL_TYP_S1    = 3'h1;
  localparam logic [2:0]  SLPCTL_TYP_S2    = 3'h2;
  localparam logic [2:0]  SLPCTL_TYP_S3    = 3'h3;
  localparam logic [2:0]  SLPCTL_TYP_S4    = 3'h4;
  localparam logic [2:0]  SLPCTL_TYP_S5    = 3'h5;
  localparam logic [7:0]  SLPCTL_HIB_REQ   = 8'h5a;
  // host register offsets (AHB-Lite, byte addresses)
  localparam logic [7:0]  SLPCTL_OFF_CMD   = 8'h00;
  localparam logic [7:0]  SLPCTL_OFF_WAKEN = 8'h04;
  localparam logic [7:0]  SLPCTL_OFF_STAT  = 8'h08;
  localparam logic [7:0]  SLPCTL_OFF_IRQS  = 8'h0c;
  localparam logic [7:0]  SLPCTL_OFF_IRQM  = 8'h10;
  localparam logic [7:0]  SLPCTL_OFF_SMI   = 8'h14;
  // CMD fields
  localparam int          SLPCTL_CMD_TYPA  = 0;
  localparam int          SLPCTL_CMD_TYPB  = 4;
  localparam int          SLPCTL_CMD_GO    = 8;
  // interrupt status bits
  localparam int          SLPCTL_IRQ_SLEPT = 0;
  localparam int          SLPCTL_IRQ_WOKE  = 1;
  localparam int          SLPCTL_IRQ_W     = 2;
  localparam logic [1:0]  SLPCTL_HTRANS_NS = 2'h2;
  typedef enum logic [1:0] {
    SLPCTL_WORKING = 2'b00,
    SLPCTL_ENTER   = 2'b01,
    SLPCTL_ASLEEP  = 2'b10
  } slpctl_state_t;
endpackage : slpctl_pkg

//--- hw/slpctl_if.sv
// link between the power manager host end and the device end
// assumes both ends on the same clock
`timescale 1ns/1ps
interface slpctl_if;
  import slpctl_pkg::*;
  logic                     ctl_wr_a;   // write strobe, instance a
  logic                     ctl_wr_b;   // write strobe, instance b
  logic [SLPCTL_DATA_W-1:0] ctl_wdata;  // control write data
  logic                     smi_wr;     // sys mgmt command port strobe
  logic [7:0]               smi_data;   // sys mgmt command value
  logic [SLPCTL_WAKE_W-1:0] wake_en;    // per-event wake enables
  logic                     wake_sts;   // wake status flag
  logic                     sleeping;   // device asleep
  logic                     wake_clr;   // clear wake status flag
  modport dev  (input ctl_wr_a, ctl_wr_b, ctl_wdata, smi_wr, smi_data,
                wake_en, wake_clr, output wake_sts, sleeping);
  modport host (output ctl_wr_a, ctl_wr_b, ctl_wdata, smi_wr, smi_data,
                wake_en, wake_clr, input wake_sts, sleeping);
endinterface : slpctl_if

//--- hw/slpctl_dev.sv
// device end: sleep type fields, sleep enable, stop-clock request, wake
// assumes host writes whole control words on one-cycle strobes
`timescale 1ns/1ps
module slpctl_dev (
  input  wire logic                              SYS_CLK_I,   // clock
  input  wire logic                              RST_N_I,     // reset
  slpctl_if.dev                                  LINK,        // link
  input  wire logic [slpctl_pkg::SLPCTL_WAKE_W-1:0] WAKE_EV_I, // events
  output logic                                   STOP_CLK_O,  // stop-clock
  output logic                                   SYS_CLK_RUN_O, // bus clk
  output logic                                   CPU_CLK_RUN_O, // cpu clk
  output logic [slpctl_pkg::SLPCTL_TYPE_W-1:0]   SLP_TYPE_O   // sleep type
);
  import slpctl_pkg::*;
  logic [SLPCTL_TYPE_W-1:0] type_a_r;
  logic [SLPCTL_TYPE_W-1:0] type_b_r;
  logic                     slp_req_r;
  logic                     wake_sts_r;
  logic                     any_wake;
  logic                     ctl_wr;
  logic                     en_bit;
  logic [SLPCTL_TYPE_W-1:0] wr_type;
  slpctl_state_t            state_r;

  assign ctl_wr   = LINK.ctl_wr_a | LINK.ctl_wr_b;
  assign en_bit   = LINK.ctl_wdata[SLPCTL_EN_BIT];
  assign wr_type  = LINK.ctl_wdata[SLPCTL_TYPE_LSB +: SLPCTL_TYPE_W];
  assign any_wake = |(WAKE_EV_I & LINK.wake_en); // RULE_06

  // each instance keeps its own type field
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      type_a_r <= SLPCTL_TYP_WORK;
    end else if (LINK.ctl_wr_a) begin
      type_a_r <= wr_type; // RULE_01 RULE_03
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      type_b_r <= SLPCTL_TYP_WORK;
    end else if (LINK.ctl_wr_b) begin
      type_b_r <= wr_type; // RULE_03
    end
  end

  // request only from a control write with enable set; smi port ignored
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slp_req_r <= 1'b0;
    end else if (state_r == SLPCTL_ASLEEP && any_wake) begin
      slp_req_r <= 1'b0; // RULE_14
    end else if (ctl_wr && en_bit && state_r == SLPCTL_WORKING) begin
      slp_req_r <= 1'b1; // RULE_02 RULE_04 RULE_11
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= SLPCTL_WORKING;
    end else begin
      unique case (state_r)
        SLPCTL_WORKING: begin
          if (ctl_wr && en_bit) begin
            state_r <= SLPCTL_ENTER; // RULE_02
          end
        end
        SLPCTL_ENTER: begin
          state_r <= SLPCTL_ASLEEP;
        end
        SLPCTL_ASLEEP: begin
          if (any_wake) begin
            state_r <= SLPCTL_WORKING; // RULE_09
          end
        end
        default: begin
          state_r <= SLPCTL_WORKING;
        end
      endcase
    end
  end

  // set wins over clear
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_sts_r <= 1'b0;
    end else if (state_r == SLPCTL_ASLEEP) begin
      wake_sts_r <= 1'b1; // RULE_05
    end else if (LINK.wake_clr) begin
      wake_sts_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      STOP_CLK_O <= 1'b0;
    end else if (state_r == SLPCTL_ASLEEP && any_wake) begin
      STOP_CLK_O <= 1'b0; // RULE_09
    end else if (state_r == SLPCTL_ENTER && type_a_r == SLPCTL_TYP_S1) begin
      STOP_CLK_O <= 1'b1; // RULE_07
    end
  end

  // clocks stop for every type other than S1, WORK included
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SYS_CLK_RUN_O <= 1'b1;
      CPU_CLK_RUN_O <= 1'b1;
    end else begin
      SYS_CLK_RUN_O <= !(slp_req_r && state_r == SLPCTL_ASLEEP &&
                         type_a_r != SLPCTL_TYP_S1); // RULE_08
      CPU_CLK_RUN_O <= !(slp_req_r && state_r == SLPCTL_ASLEEP &&
                         type_a_r != SLPCTL_TYP_S1); // RULE_08
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SLP_TYPE_O <= SLPCTL_TYP_WORK;
    end else begin
      SLP_TYPE_O <= type_a_r;
    end
  end

  assign LINK.wake_sts = wake_sts_r;
  assign LINK.sleeping = (state_r == SLPCTL_ASLEEP);
endmodule : slpctl_dev

//--- hw/slpctl_host.sv
// host end: AHB-Lite slave registers drive the power manager link
// Behaviour
// RULE_01: three-bit sleep type field written by software
// RULE_02: setting sleep enable starts the transition
// RULE_03: two instances, each given its own type
// RULE_04: type and enable go in one write
// RULE_05: wake status set while sleeping
// RULE_06: only enabled wake events wake the device
// RULE_07: S1 with enable asserts stop-clock request
// RULE_08: S1 keeps bus and cpu clocks running
// RULE_09: enabled wake drops the stop-clock request
// RULE_10: firmware hibernate uses command port, not enable
// RULE_11: only the enable write starts sequencing
// RULE_12: software idles a cpu lacking hardware path
// RULE_13: software flushes caches before S1 to S3
// RULE_14: wake clears the internal sleep request
`timescale 1ns/1ps
module slpctl_host (
  input  wire logic        SYS_CLK_I,  // clock
  input  wire logic        RST_N_I,    // reset
  slpctl_if.host           LINK,       // link
  input  wire logic        HSEL_I,     // slave select
  input  wire logic [31:0] HADDR_I,    // address
  input  wire logic [1:0]  HTRANS_I,   // transfer type
  input  wire logic        HWRITE_I,   // write
  input  wire logic [2:0]  HSIZE_I,    // size, word only
  input  wire logic [31:0] HWDATA_I,   // write data
  input  wire logic        HREADY_I,   // bus ready
  output logic [31:0]      HRDATA_O,   // read data
  output logic             HREADYOUT_O, // low in reset, then always ready
  output logic             HRESP_O,    // always okay
  output logic             IRQ_O       // interrupt level
);
  import slpctl_pkg::*;
  logic                     ph_wr_r;
  logic                     ph_rd_r;
  logic [7:0]               ph_addr_r;
  logic                     take;
  logic                     wr_cmd;
  logic [SLPCTL_WAKE_W-1:0] waken_r;
  logic [SLPCTL_IRQ_W-1:0]  irqs_r;
  logic [SLPCTL_IRQ_W-1:0]  irqm_r;
  logic                     sleeping_d_r;
  logic                     slept_ev;
  logic                     woke_ev;
  logic                     ctl_wr_a_r;
  logic                     ctl_wr_b_r;
  logic [SLPCTL_DATA_W-1:0] ctl_wdata_r;
  logic                     smi_wr_r;
  logic [7:0]               smi_data_r;
  logic                     wake_clr_r;
  logic [SLPCTL_TYPE_W-1:0] typ_b_r;

  assign take     = HSEL_I && HREADY_I && HTRANS_I == SLPCTL_HTRANS_NS;
  assign wr_cmd   = ph_wr_r && ph_addr_r == SLPCTL_OFF_CMD;
  assign slept_ev = LINK.sleeping && !sleeping_d_r;
  assign woke_ev  = !LINK.sleeping && sleeping_d_r;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_wr_r   <= take && HWRITE_I;
      ph_rd_r   <= take && !HWRITE_I;
      ph_addr_r <= HADDR_I[7:0];
    end
  end

  // one CMD write carries both types and the enable together
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_wr_a_r  <= 1'b0;
      ctl_wr_b_r  <= 1'b0;
      ctl_wdata_r <= 32'h0000_0000;
    end else begin
      ctl_wr_a_r  <= wr_cmd; // RULE_04
      ctl_wr_b_r  <= ctl_wr_a_r; // RULE_03
      ctl_wdata_r <= 32'h0000_0000;
      if (wr_cmd) begin
        ctl_wdata_r[SLPCTL_TYPE_LSB +: SLPCTL_TYPE_W] <=
          HWDATA_I[SLPCTL_CMD_TYPA +: SLPCTL_TYPE_W]; // RULE_01
        ctl_wdata_r[SLPCTL_EN_BIT] <= HWDATA_I[SLPCTL_CMD_GO]; // RULE_02
      end else if (ctl_wr_a_r) begin
        // type only: the enable already went with instance a
        ctl_wdata_r[SLPCTL_TYPE_LSB +: SLPCTL_TYPE_W] <= typ_b_r; // RULE_03
      end
    end
  end

  // instance b gets its own type a cycle later over the shared data
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      typ_b_r <= SLPCTL_TYP_WORK;
    end else if (wr_cmd) begin
      typ_b_r <= HWDATA_I[SLPCTL_CMD_TYPB +: SLPCTL_TYPE_W]; // RULE_03
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      smi_wr_r   <= 1'b0;
      smi_data_r <= 8'h00;
    end else begin
      smi_wr_r   <= ph_wr_r && ph_addr_r == SLPCTL_OFF_SMI; // RULE_10
      smi_data_r <= HWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      waken_r    <= '0;
      irqm_r     <= '0;
      wake_clr_r <= 1'b0;
    end else begin
      wake_clr_r <= ph_wr_r && ph_addr_r == SLPCTL_OFF_STAT && HWDATA_I[0];
      if (ph_wr_r && ph_addr_r == SLPCTL_OFF_WAKEN) begin
        waken_r <= HWDATA_I[SLPCTL_WAKE_W-1:0]; // RULE_06
      end
      if (ph_wr_r && ph_addr_r == SLPCTL_OFF_IRQM) begin
        irqm_r <= HWDATA_I[SLPCTL_IRQ_W-1:0];
      end
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sleeping_d_r <= 1'b0;
      irqs_r       <= '0;
    end else begin
      sleeping_d_r <= LINK.sleeping;
      irqs_r <= (irqs_r & ~((ph_wr_r && ph_addr_r == SLPCTL_OFF_IRQS) ?
                HWDATA_I[SLPCTL_IRQ_W-1:0] : '0)) |
                {woke_ev, slept_ev};
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irqs_r & irqm_r);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (take && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        SLPCTL_OFF_CMD:   HRDATA_O <= {29'h0, ctl_wdata_r[SLPCTL_TYPE_LSB +:
                                       SLPCTL_TYPE_W]};
        SLPCTL_OFF_WAKEN: HRDATA_O <= {24'h0, waken_r};
        SLPCTL_OFF_STAT:  HRDATA_O <= {30'h0, LINK.sleeping, LINK.wake_sts};
        SLPCTL_OFF_IRQS:  HRDATA_O <= {30'h0, irqs_r};
        SLPCTL_OFF_IRQM:  HRDATA_O <= {30'h0, irqm_r};
        default:          HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  assign LINK.ctl_wr_a  = ctl_wr_a_r;
  assign LINK.ctl_wr_b  = ctl_wr_b_r;
  assign LINK.ctl_wdata = ctl_wdata_r;
  assign LINK.smi_wr    = smi_wr_r;
  assign LINK.smi_data  = smi_data_r;
  assign LINK.wake_en   = waken_r;
  assign LINK.wake_clr  = wake_clr_r;
endmodule : slpctl_host

//--- verif/slpctl_props.sv
// assertions on the link and the device outputs
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
module slpctl_props
  import slpctl_pkg::*;
(
  input wire logic                     SYS_CLK_I,     // clock
  input wire logic                     RST_N_I,       // reset
  input wire logic                     ctl_wr_a,      // write strobe a
  input wire logic [SLPCTL_DATA_W-1:0] ctl_wdata,     // control word
  input wire logic [SLPCTL_WAKE_W-1:0] wake_en,       // wake enables
  input wire logic                     wake_sts,      // wake status
  input wire logic                     sleeping,      // asleep
  input wire logic                     wake_clr,      // status clear
  input wire logic [SLPCTL_WAKE_W-1:0] WAKE_EV_I,     // wake events
  input wire logic                     STOP_CLK_O,    // stop-clock
  input wire logic                     SYS_CLK_RUN_O, // bus clock on
  input wire logic                     CPU_CLK_RUN_O, // cpu clock on
  input wire logic [2:0]               SLP_TYPE_O     // sleep type
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic wake_hit;
  assign wake_hit = |(WAKE_EV_I & wake_en);
  entry_on_en_a: assert property (
    ctl_wr_a && ctl_wdata[SLPCTL_EN_BIT] && !sleeping |-> ##2 sleeping)
    else $error("no sleep after enable write");
  entry_cause_a: assert property (
    $rose(sleeping) |-> $past(ctl_wr_a && ctl_wdata[SLPCTL_EN_BIT], 2))
    else $error("sleep without enable write");
  sts_set_a: assert property (
    sleeping |-> ##[0:1] wake_sts) else $error("wake status not set");
  sts_sticky_a: assert property (
    wake_sts && !wake_clr |=> wake_sts) else $error("wake status lost");
  wake_exit_a: assert property (
    sleeping && wake_hit |=> !sleeping) else $error("stayed asleep");
  wake_gate_a: assert property (
    sleeping && !wake_hit |=> sleeping) else $error("woke unenabled");
  stop_on_s1_a: assert property (
    $rose(sleeping) && SLP_TYPE_O == SLPCTL_TYP_S1 |-> ##[0:1] STOP_CLK_O)
    else $error("no stop-clock in s1");
  stop_type_a: assert property (
    STOP_CLK_O |-> sleeping && SLP_TYPE_O == SLPCTL_TYP_S1)
    else $error("stop-clock outside s1");
  clk_run_a: assert property (
    STOP_CLK_O |-> SYS_CLK_RUN_O && CPU_CLK_RUN_O)
    else $error("clock stopped in s1");
  stop_drop_a: assert property (
    STOP_CLK_O && wake_hit |=> !STOP_CLK_O) else $error("stop-clock held");
endmodule : slpctl_props

//--- verif/testbench.sv
// self-checking bench: host and device ends joined by the link
// assumes package, interface and both ends are compiled first
`timescale 1ns/1ps
module testbench;
  import slpctl_pkg::*;
  `define CHK(nm, ex, gt) begin \
    compares++; \
    if ((gt) !== (ex)) begin \
      failures++; \
      $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
  logic        clk, rst_n, hsel, hwrite, hready, hresp, irq;
  logic        stop_clk, sys_run, cpu_run;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  wake_ev;
  logic [2:0]  slp_type, seen_b;
  int          failures, compares, cyc, exp_b;
  int          typb_q[$];
  slpctl_if lnk ();
  slpctl_host slpctl_host_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .IRQ_O(irq));
  slpctl_dev slpctl_dev_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk),
    .WAKE_EV_I(wake_ev), .STOP_CLK_O(stop_clk), .SYS_CLK_RUN_O(sys_run),
    .CPU_CLK_RUN_O(cpu_run), .SLP_TYPE_O(slp_type));
  slpctl_props slpctl_props_i (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .ctl_wr_a(lnk.ctl_wr_a), .ctl_wdata(lnk.ctl_wdata),
    .wake_en(lnk.wake_en), .wake_sts(lnk.wake_sts),
    .sleeping(lnk.sleeping), .wake_clr(lnk.wake_clr), .WAKE_EV_I(wake_ev),
    .STOP_CLK_O(stop_clk), .SYS_CLK_RUN_O(sys_run),
    .CPU_CLK_RUN_O(cpu_run), .SLP_TYPE_O(slp_type));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // model: instance b strobes carry the queued type b values in order
  always @(posedge clk) begin
    if (lnk.ctl_wr_b) begin
      seen_b <= lnk.ctl_wdata[12:10];
      exp_b  <= (typb_q.size() > 0) ? typb_q.pop_front() : -1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic ahb(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= SLPCTL_HTRANS_NS;
    hwrite <= wr;
    haddr  <= {24'h0, adr};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdv = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb
  task automatic wait_sleep(input logic v);
    for (int i = 0; i < 20 && lnk.sleeping !== v; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : wait_sleep
  initial begin
    logic [7:0] mask;
    logic [2:0] typb;
    logic [1:0] irqm;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    wake_ev = 8'h0;
    seen_b = 3'h0;
    exp_b = 0;
    rd = $urandom(21374);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    ahb(1'b0, SLPCTL_OFF_STAT, 32'h0, rd);
    `CHK("stat_rst", 32'h0, rd)
    ahb(1'b0, 8'h20, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, SLPCTL_OFF_SMI, {24'h0, SLPCTL_HIB_REQ}, rd);
    typb_q.push_back(0);
    ahb(1'b1, SLPCTL_OFF_CMD, 32'h1, rd);
    wait_sleep(1'b1);
    `CHK("no_sleep", 1'b0, lnk.sleeping)
    $display("test refusals done");
    for (int t = 1; t <= 5; t++) begin
      mask = 8'($urandom_range(255, 1));
      typb = 3'($urandom_range(7, 0));
      irqm = 2'($urandom_range(3, 0));
      ahb(1'b1, SLPCTL_OFF_WAKEN, {24'h0, mask}, rd);
      ahb(1'b1, SLPCTL_OFF_IRQM, {30'h0, irqm}, rd);
      typb_q.push_back(typb);
      ahb(1'b1, SLPCTL_OFF_CMD, {23'h0, 2'h2, typb, 1'b0, 3'(t)}, rd);
      wait_sleep(1'b1);
      `CHK("type_a", 3'(t), slp_type)
      `CHK("type_b", typb, seen_b)
      `CHK("model_b", exp_b, seen_b)
      `CHK("stop_clk", (t == 1), stop_clk)
      `CHK("clk_run", (t == 1) ? 2'h3 : 2'h0, {sys_run, cpu_run})
      `CHK("irq_slept", irqm[0], irq)
      ahb(1'b0, SLPCTL_OFF_STAT, 32'h0, rd);
      `CHK("stat_sleep", 32'h3, rd)
      wake_ev <= ~mask;
      repeat (4) @(posedge clk);
      `CHK("gated", 1'b1, lnk.sleeping)
      wake_ev <= mask & (~mask + 8'h1);
      wait_sleep(1'b0);
      `CHK("woke", 1'b0, lnk.sleeping)
      `CHK("stop_rel", 1'b0, stop_clk)
      wake_ev <= 8'h0;
      ahb(1'b0, SLPCTL_OFF_IRQS, 32'h0, rd);
      `CHK("irqs", 32'h3, rd)
      `CHK("irq", |irqm, irq)
      ahb(1'b1, SLPCTL_OFF_IRQS, 32'h3, rd);
      ahb(1'b1, SLPCTL_OFF_STAT, 32'h1, rd);
      ahb(1'b0, SLPCTL_OFF_STAT, 32'h0, rd);
      `CHK("stat_clr", 32'h0, rd)
      `CHK("irq_clr", 1'b0, irq)
      $display("test sleep type %0d done", t);
    end
    `CHK("b_queue", 0, typb_q.size())
    tally_and_finish();
  end
endmodule : testbench
